/* dbs_pkg.sv */
// shared constants for the display bias setpoint and flag register slice
`default_nettype none
package dbs_pkg;
    // register addresses on the serial register port
    localparam logic [7:0] ADDR_BIAS_BOOST = 8'h0D;
    localparam logic [7:0] ADDR_POS_RAIL = 8'h0E;
    localparam logic [7:0] ADDR_NEG_RAIL = 8'h0F;
    localparam logic [7:0] ADDR_PROTECTION_FLAGS_SECOND = 8'h10;
    // level field layout and reset values
    localparam int LEVEL_W = 6;
    localparam logic [5:0] BIAS_BOOST_RST = 6'h1E;
    localparam logic [5:0] POS_RAIL_RST = 6'h1E;
    localparam logic [5:0] NEG_RAIL_RST = 6'h1C;
    // flag bit positions and reset value
    localparam int FLAG_W = 6;
    localparam int FLAG_BACKLIGHT_BOOST_OVERCURRENT = 0;
    localparam int FLAG_FLASH_BOOST_OVERCURRENT = 1;
    localparam int FLAG_NEG_SHORT = 2;
    localparam int FLAG_POS_SHORT = 3;
    localparam int FLAG_NEG_OVP = 4;
    localparam int FLAG_BOOST_OVP = 5;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    // target voltage mapping, millivolts (negative rail given as magnitude)
    localparam int MV_W = 13;
    localparam logic [12:0] BOOST_BASE_MV = 13'h1194;
    localparam logic [12:0] POS_BASE_MV = 13'h0FA0;
    localparam logic [12:0] NEG_BASE_MV = 13'h0FA0;
    localparam logic [12:0] STEP_MV = 13'h0032;
    // serial port defaults
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h36;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : dbs_pkg
`default_nettype wire

/* dbs_sync.sv */
// two-flop synchroniser bank for pins entering the mclk domain
`default_nettype none
module dbs_sync
    import dbs_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] async_in,
    output var logic [WIDTH-1:0] sync_out
);
    // one chain per bit; the first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta;
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                meta <= RST_VAL[i];
                sync_out[i] <= RST_VAL[i];
            end else begin
                meta <= async_in[i];
                sync_out[i] <= meta;
            end
        end
    end
endmodule : dbs_sync
`default_nettype wire

/* dbs_bank.sv */
// setpoint registers, second flag register and rail enable steering
//
// Overview of operation
// - boost target 4.5 V plus 50 mV per code
// - boost level at 0x0D, resets to 0x1E
// - positive rail 4 V plus 50 mV per code
// - positive level at 0x0E, resets to 0x1E
// - negative rail -4 V, -50 mV per code
// - negative level at 0x0F, resets to 0x1C
// - flag register 0x10 resets zero, read-only
// - bit 5 reports boost overvoltage
// - bit 4 reports negative rail overvoltage
// - bit 3 reports positive rail short
// - bit 2 reports negative rail short
// - bit 1 reports flash boost overcurrent
// - bit 0 reports backlight boost overcurrent
// - each function follows only its own enable, except the boost, which runs while either rail is enabled
// - select bit chooses pins or register enables
`default_nettype none
module dbs_bank
    import dbs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // serial register port, sda open drain
    input wire logic scl,
    input wire logic sda_in,
    output var logic sda_out,
    output var logic sda_oe,
    // enable controls from the configuration slice
    input wire logic pin_enable_select,
    input wire logic positive_rail_enable_bit,
    input wire logic negative_rail_enable_bit,
    input wire logic backlight_enable_bit,
    input wire logic flash_enable_bit,
    // external enable pins
    input wire logic positive_rail_enable_pin,
    input wire logic negative_rail_enable_pin,
    // protection events from the analog side
    input wire logic bias_boost_overvoltage,
    input wire logic negative_rail_overvoltage,
    input wire logic positive_rail_shorted,
    input wire logic negative_rail_shorted,
    input wire logic flash_boost_overcurrent,
    input wire logic backlight_boost_overcurrent,
    // setpoints to the regulators
    output var logic [5:0] bias_boost_code,
    output var logic [5:0] positive_rail_code,
    output var logic [5:0] negative_rail_code,
    output var logic [12:0] bias_boost_mv,
    output var logic [12:0] positive_rail_mv,
    output var logic [12:0] negative_rail_mv_mag,
    // function enables
    output var logic positive_rail_on,
    output var logic negative_rail_on,
    output var logic bias_boost_on,
    output var logic backlight_on,
    output var logic flash_on,
    // flag view
    output var logic [5:0] flags_second
);
    typedef enum logic [3:0] {
        DBS_IDLE, DBS_ADDR, DBS_ADDR_ACK, DBS_REG, DBS_REG_ACK,
        DBS_WDATA, DBS_WDATA_ACK, DBS_RDATA, DBS_RDATA_ACK
    } dbs_state_e;

    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic [1:0] en_pins_s;
    logic [5:0] events_s;
    logic [5:0] events_raw;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    dbs_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [7:0] reg_ptr;
    logic rw_bit;
    logic host_nack;
    logic wr_pulse;
    logic [7:0] wr_data;
    logic [7:0] rd_byte;
    logic [5:0] flag_clear;
    logic [5:0] next_flags;

    // pins from the host and analog side cross into mclk
    dbs_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync_bus (
        .mclk(mclk),
        .rst(rst),
        .async_in({scl, sda_in}),
        .sync_out({scl_s, sda_s})
    );

    dbs_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_sync_en (
        .mclk(mclk),
        .rst(rst),
        .async_in({positive_rail_enable_pin, negative_rail_enable_pin}),
        .sync_out(en_pins_s)
    );

    // event bits packed at their flag positions
    always_comb begin
        events_raw = 6'h00;
        events_raw[FLAG_BOOST_OVP] = bias_boost_overvoltage;
        events_raw[FLAG_NEG_OVP] = negative_rail_overvoltage;
        events_raw[FLAG_POS_SHORT] = positive_rail_shorted;
        events_raw[FLAG_NEG_SHORT] = negative_rail_shorted;
        events_raw[FLAG_FLASH_BOOST_OVERCURRENT] = flash_boost_overcurrent;
        events_raw[FLAG_BACKLIGHT_BOOST_OVERCURRENT] = backlight_boost_overcurrent;
    end

    dbs_sync #(.WIDTH(FLAG_W), .RST_VAL(FLAGS_RST)) u_sync_evt (
        .mclk(mclk),
        .rst(rst),
        .async_in(events_raw),
        .sync_out(events_s)
    );

    // delayed copies of the synchronised bus lines for edge finding
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    // sda moving while scl high frames a transfer
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // read view; unmapped addresses read zero
    always_comb begin
        rd_byte = 8'h00;
        if (reg_ptr == ADDR_BIAS_BOOST) begin
            rd_byte = {2'b00, bias_boost_code};
        end else if (reg_ptr == ADDR_POS_RAIL) begin
            rd_byte = {2'b00, positive_rail_code};
        end else if (reg_ptr == ADDR_NEG_RAIL) begin
            rd_byte = {2'b00, negative_rail_code};
        end else if (reg_ptr == ADDR_PROTECTION_FLAGS_SECOND) begin
            rd_byte = {2'b00, flags_second};
        end
    end

    // bit receive: data sampled on scl rising
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shift_in <= 8'h00;
            host_nack <= 1'b0;
        end else if (scl_rise) begin
            shift_in <= {shift_in[6:0], sda_s};
            if (state == DBS_RDATA_ACK) begin
                host_nack <= sda_s;
            end
        end
    end

    // bit counter; the acknowledge slot is the ninth count, so the
    // next byte starts from zero instead of one bit early
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bit_cnt <= 4'h0;
        end else if (start_det) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && bit_cnt != BITS_PER_BYTE + 4'h1) begin
            bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_fall && bit_cnt == BITS_PER_BYTE + 4'h1) begin
            bit_cnt <= 4'h0;
        end
    end

    // transfer sequencing; outputs change on scl falling
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= DBS_IDLE;
            sda_oe <= 1'b0;
            rw_bit <= 1'b0;
            reg_ptr <= 8'h00;
            shift_out <= 8'h00;
            wr_pulse <= 1'b0;
            wr_data <= 8'h00;
            flag_clear <= 6'h00;
        end else begin
            wr_pulse <= 1'b0;
            flag_clear <= 6'h00;
            if (start_det) begin
                state <= DBS_ADDR;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state <= DBS_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_fall) begin
                case (state)
                    DBS_ADDR: begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            if (shift_in[7:1] == DEV_ADDR) begin
                                rw_bit <= shift_in[0];
                                sda_oe <= 1'b1;
                                state <= DBS_ADDR_ACK;
                            end else begin
                                state <= DBS_IDLE;
                            end
                        end
                    end
                    DBS_ADDR_ACK: begin
                        if (rw_bit) begin
                            shift_out <= rd_byte;
                            // flags clear as their byte is loaded for sending
                            if (reg_ptr == ADDR_PROTECTION_FLAGS_SECOND) begin
                                flag_clear <= 6'h3F;
                            end
                            sda_oe <= ~rd_byte[7];
                            state <= DBS_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= DBS_REG;
                        end
                    end
                    DBS_REG: begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            reg_ptr <= shift_in;
                            sda_oe <= 1'b1;
                            state <= DBS_REG_ACK;
                        end
                    end
                    DBS_REG_ACK: begin
                        sda_oe <= 1'b0;
                        state <= DBS_WDATA;
                    end
                    DBS_WDATA: begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            wr_data <= shift_in;
                            wr_pulse <= 1'b1;
                            sda_oe <= 1'b1;
                            state <= DBS_WDATA_ACK;
                        end
                    end
                    DBS_WDATA_ACK: begin
                        sda_oe <= 1'b0;
                        reg_ptr <= reg_ptr + 8'h01;
                        state <= DBS_WDATA;
                    end
                    DBS_RDATA: begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            sda_oe <= 1'b0;
                            state <= DBS_RDATA_ACK;
                        end else begin
                            sda_oe <= ~shift_out[3'h7 - bit_cnt[2:0]];
                        end
                    end
                    DBS_RDATA_ACK: begin
                        if (host_nack) begin
                            sda_oe <= 1'b0;
                            state <= DBS_IDLE;
                        end else begin
                            reg_ptr <= reg_ptr + 8'h01;
                            // msb of the byte staged on the ack rise
                            sda_oe <= ~shift_out[7];
                            state <= DBS_RDATA;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end else if (state == DBS_RDATA_ACK && scl_rise && !sda_s) begin
                // host acked: before scl falls, stage the flag byte if the next address is 0x10, else zero
                shift_out <= (reg_ptr + 8'h01 == ADDR_PROTECTION_FLAGS_SECOND) ? {2'b00, flags_second}
                                                              : 8'h00;
            end
        end
    end

    // the pin is only ever pulled low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // boost level register at its address
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bias_boost_code <= BIAS_BOOST_RST;
        end else if (wr_pulse && reg_ptr == ADDR_BIAS_BOOST) begin
            bias_boost_code <= wr_data[LEVEL_W-1:0];
        end
    end

    // positive level register at its address
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            positive_rail_code <= POS_RAIL_RST;
        end else if (wr_pulse && reg_ptr == ADDR_POS_RAIL) begin
            positive_rail_code <= wr_data[LEVEL_W-1:0];
        end
    end

    // negative level register at its address
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            negative_rail_code <= NEG_RAIL_RST;
        end else if (wr_pulse && reg_ptr == ADDR_NEG_RAIL) begin
            negative_rail_code <= wr_data[LEVEL_W-1:0];
        end
    end

    // sticky flags; an event in the clearing cycle survives
    always_comb begin
        next_flags = (flags_second & ~flag_clear) | events_s;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_second <= FLAGS_RST;
        end else begin
            flags_second <= next_flags;
        end
    end

    // linear code to target translation, one cycle behind the code
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bias_boost_mv <= 13'h0000;
            positive_rail_mv <= 13'h0000;
            negative_rail_mv_mag <= 13'h0000;
        end else begin
            bias_boost_mv <= 13'(BOOST_BASE_MV + 13'(bias_boost_code) * STEP_MV);
            positive_rail_mv <= 13'(POS_BASE_MV + 13'(positive_rail_code) * STEP_MV);
            negative_rail_mv_mag <= 13'(NEG_BASE_MV + 13'(negative_rail_code) * STEP_MV);
        end
    end

    // rail enables: pins and bits never mix
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            positive_rail_on <= 1'b0;
            negative_rail_on <= 1'b0;
            bias_boost_on <= 1'b0;
        end else begin
            if (pin_enable_select) begin
                positive_rail_on <= en_pins_s[1];
                negative_rail_on <= en_pins_s[0];
            end else begin
                positive_rail_on <= positive_rail_enable_bit;
                negative_rail_on <= negative_rail_enable_bit;
            end
            // boost feeds both rails, so it runs while either is wanted
            bias_boost_on <= pin_enable_select ? |en_pins_s
                : (positive_rail_enable_bit | negative_rail_enable_bit);
        end
    end

    // backlight and flash own enables only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            backlight_on <= 1'b0;
            flash_on <= 1'b0;
        end else begin
            backlight_on <= backlight_enable_bit;
            flash_on <= flash_enable_bit;
        end
    end
endmodule : dbs_bank
`default_nettype wire

/* dbs_bank_chk.sv */
// port-level assertions for the setpoint and flag register slice
`default_nettype none
module dbs_bank_chk
    import dbs_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // enable controls and pins
    input wire logic pin_enable_select,
    input wire logic positive_rail_enable_bit,
    input wire logic negative_rail_enable_pin,
    input wire logic backlight_enable_bit,
    input wire logic flash_enable_bit,
    // protection events
    input wire logic bias_boost_overvoltage,
    input wire logic backlight_boost_overcurrent,
    // setpoints, enables and flags out
    input wire logic [5:0] bias_boost_code,
    input wire logic [5:0] positive_rail_code,
    input wire logic [5:0] negative_rail_code,
    input wire logic [12:0] bias_boost_mv,
    input wire logic [12:0] positive_rail_mv,
    input wire logic [12:0] negative_rail_mv_mag,
    input wire logic positive_rail_on,
    input wire logic negative_rail_on,
    input wire logic backlight_on,
    input wire logic flash_on,
    input wire logic [5:0] flags_second
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and reset are given once
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // an event held four samples must have latched its flag
    property flag_sets(ev, fl);
        ev[*4] |=> fl;
    endproperty
    boost_mv_a: assert property (!$past(rst) |->
        bias_boost_mv == BOOST_BASE_MV + STEP_MV * $past(bias_boost_code))
        else $error("boost target does not track its code");
    pos_mv_a: assert property (!$past(rst) |->
        positive_rail_mv == POS_BASE_MV + STEP_MV * $past(positive_rail_code))
        else $error("positive target does not track its code");
    neg_mv_a: assert property (!$past(rst) |->
        negative_rail_mv_mag == NEG_BASE_MV + STEP_MV * $past(negative_rail_code))
        else $error("negative target does not track its code");
    boost_ovp_a: assert property (flag_sets(bias_boost_overvoltage, flags_second[5]))
        else $error("boost overvoltage flag not set");
    backlight_boost_overcurrent_a: assert property (flag_sets(backlight_boost_overcurrent, flags_second[0]))
        else $error("backlight overcurrent flag not set");
    bl_follow_a: assert property (!$past(rst) |->
        backlight_on == $past(backlight_enable_bit))
        else $error("backlight enable not its own");
    flash_follow_a: assert property (!$past(rst) |->
        flash_on == $past(flash_enable_bit))
        else $error("flash enable not its own");
    pos_bit_a: assert property (!$past(rst) && !$past(pin_enable_select) |->
        positive_rail_on == $past(positive_rail_enable_bit))
        else $error("positive rail ignores its register enable");
    neg_pin_a: assert property ((pin_enable_select && $stable(negative_rail_enable_pin))[*4]
        |=> negative_rail_on == $past(negative_rail_enable_pin))
        else $error("negative rail ignores its pin");
    // main scenarios reached
    cover property ($changed(bias_boost_code));
    cover property (flags_second != 6'h00 ##1 flags_second == 6'h00);
    cover property (pin_enable_select && negative_rail_on);
endmodule : dbs_bank_chk
bind dbs_bank dbs_bank_chk chk (.mclk(mclk), .rst(rst), .pin_enable_select(pin_enable_select),
    .positive_rail_enable_bit(positive_rail_enable_bit), .flash_enable_bit(flash_enable_bit),
    .negative_rail_enable_pin(negative_rail_enable_pin), .flags_second(flags_second),
    .backlight_enable_bit(backlight_enable_bit), .bias_boost_code(bias_boost_code),
    .bias_boost_overvoltage(bias_boost_overvoltage), .positive_rail_code(positive_rail_code),
    .backlight_boost_overcurrent(backlight_boost_overcurrent), .bias_boost_mv(bias_boost_mv),
    .negative_rail_code(negative_rail_code), .positive_rail_mv(positive_rail_mv),
    .negative_rail_mv_mag(negative_rail_mv_mag), .positive_rail_on(positive_rail_on),
    .negative_rail_on(negative_rail_on), .backlight_on(backlight_on), .flash_on(flash_on));
`default_nettype wire

/* dbs_host.sv */
// host controller model for the serial register port
`default_nettype none
module dbs_host
    import dbs_pkg::*;
(
    // clock
    input wire logic mclk,
    // serial port wires, sda open drain
    input wire logic sda_line,
    output var logic scl,
    output var logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus: both lines released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // quarter bit, keeps each scl phase at 6 mclk
    task automatic q();
        repeat (3) @(negedge mclk);
    endtask : q
    // sda moves mid-way through scl low, never beside an scl edge
    task automatic bit_io(input logic b, output logic s);
        q();
        sda_low = !b;
        q();
        scl = 1'b1;
        q();
        s = sda_line;
        q();
        scl = 1'b0;
    endtask : bit_io
    // start or repeated start
    task automatic start();
        q();
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask : stop
    // eight bits msb first, then the ninth; ack means sda held low there
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], s);
            rx[i] = s;
        end
        bit_io(last, s);
        ack = !s;
    endtask : xfer
    // write n bytes from reg_a on; a wrong dev is how refusal is provoked
    task automatic wr(input logic [6:0] dev, input logic [7:0] reg_a, input logic [23:0] d,
                      input int n, output logic ok);
        logic [7:0] rx;
        logic a;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, ok);
        xfer(reg_a, 1'b1, rx, a);
        ok = ok & a;
        for (int i = 0; i < n; i++) begin
            xfer(d[23-8*i -: 8], 1'b1, rx, a);
            ok = ok & a;
        end
        stop();
    endtask : wr
    // single byte read, nack ends it
    task automatic rd(input logic [7:0] reg_a, output logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a;
        logic b;
        start();
        xfer({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, a);
        xfer(reg_a, 1'b1, rx, b);
        start();
        xfer({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, rx, ok);
        ok = ok & a & b;
        xfer(8'hFF, 1'b1, d, a);
        stop();
    endtask : rd
endmodule : dbs_host
`default_nettype wire

/* test_dbs_bank.sv */
// self-checking bench for the setpoint and flag register slice
`default_nettype none
module test_dbs_bank
    import dbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0, pbit = 1'b0, nbit = 1'b0, ppin = 1'b0, npin = 1'b0, bl = 1'b0, fl = 1'b0;
    logic [5:0] ev = 6'h00;
    logic scl, sda_low, sda_oe, sda_out, pon, non, bon, blon, flon;
    logic [5:0] bcode, pcode, ncode, flags;
    logic [12:0] bmv, pmv, nmv;
    // open-drain wire: low if either side pulls, else pull-up
    wire logic sda_line = !(sda_oe || sda_low);
    int error_cnt = 0;
    int comparisons = 0;
    dbs_bank dut (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .pin_enable_select(sel), .positive_rail_enable_bit(pbit),
        .negative_rail_enable_bit(nbit), .backlight_enable_bit(bl), .flash_enable_bit(fl),
        .positive_rail_enable_pin(ppin), .negative_rail_enable_pin(npin),
        .bias_boost_overvoltage(ev[5]), .negative_rail_overvoltage(ev[4]),
        .positive_rail_shorted(ev[3]), .negative_rail_shorted(ev[2]),
        .flash_boost_overcurrent(ev[1]), .backlight_boost_overcurrent(ev[0]),
        .bias_boost_code(bcode), .positive_rail_code(pcode), .negative_rail_code(ncode),
        .bias_boost_mv(bmv), .positive_rail_mv(pmv), .negative_rail_mv_mag(nmv),
        .positive_rail_on(pon), .negative_rail_on(non), .bias_boost_on(bon),
        .backlight_on(blon), .flash_on(flon), .flags_second(flags));
    dbs_host host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // reset values at the ports and over the bus
    task automatic t_reset();
        logic [7:0] d;
        logic ok;
        chk({bcode, pcode, ncode}, 18'h1E79C);
        chk(flags, 16'h0000);
        chk(bmv, 16'h1770);
        chk(pmv, 16'h157C);
        chk(nmv, 16'h1518);
        host.rd(ADDR_BIAS_BOOST, d, ok);
        chk({ok, d}, 16'h011E);
        host.rd(ADDR_POS_RAIL, d, ok);
        chk({ok, d}, 16'h011E);
        host.rd(ADDR_NEG_RAIL, d, ok);
        chk({ok, d}, 16'h011C);
    endtask : t_reset
    // burst write with reserved bits set, boundary codes
    task automatic t_write();
        logic [7:0] d;
        logic ok;
        host.wr(DEV_ADDR_DEFAULT, ADDR_BIAS_BOOST, 24'hFFC025, 3, ok);
        chk({ok, bcode, pcode, ncode}, 19'h7F025);
        chk(bmv, 16'h1DE2);
        chk(pmv, 16'h0FA0);
        chk(nmv, 16'h16DA);
        host.rd(ADDR_BIAS_BOOST, d, ok);
        chk({ok, d}, 16'h013F);
        host.rd(ADDR_NEG_RAIL, d, ok);
        chk({ok, d}, 16'h0125);
    endtask : t_write
    // foreign address, read-only flags, unmapped place
    task automatic t_refused();
        logic [7:0] d;
        logic ok;
        host.wr(7'h37, ADDR_BIAS_BOOST, 24'h010000, 1, ok);
        chk({ok, bcode}, 16'h003F);
        host.wr(DEV_ADDR_DEFAULT, ADDR_PROTECTION_FLAGS_SECOND, 24'h3F0000, 1, ok);
        chk({ok, flags}, 16'h0040);
        host.rd(8'h20, d, ok);
        chk({ok, d}, 16'h0100);
    endtask : t_refused
    // each event lands in its own flag bit
    task automatic t_flags();
        logic [7:0] d;
        logic ok;
        for (int i = 0; i < FLAG_W; i++) begin
            ev[i] = 1'b1;
            repeat (8) @(negedge mclk);
            ev[i] = 1'b0;
            repeat (4) @(negedge mclk);
            chk(flags, 16'h0001 << i);
            host.rd(ADDR_PROTECTION_FLAGS_SECOND, d, ok);
            chk({ok, d}, 16'h0100 | (16'h0001 << i));
            chk(flags, 16'h0000);
        end
    endtask : t_flags
    // every mix of select, bits and pins
    task automatic t_enables();
        logic p;
        logic n;
        for (int v = 0; v < 128; v++) begin
            {sel, pbit, nbit, ppin, npin, bl, fl} = v[6:0];
            repeat (6) @(negedge mclk);
            p = sel ? ppin : pbit;
            n = sel ? npin : nbit;
            chk({pon, non, bon, blon, flon}, {p, n, p | n, bl, fl});
        end
    endtask : t_enables
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // main sequence; synchronisers settle before the first transfer
    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        repeat (6) @(negedge mclk);
        t_reset();
        t_write();
        t_refused();
        t_flags();
        t_enables();
        print_verdict();
    end
    // watchdog: the tests need just under a fifth of this
    initial begin
        #200us;
        error_cnt++;
        print_verdict();
    end
endmodule : test_dbs_bank
`default_nettype wire
